// ===== host_spi_model.sv
// Host controller model: SPI mode 0 master on the register port.
// Assumes one frame at a time, driven on falling clock edges.
module host_spi_model (
   input  wire logic i_clock,
   output logic      o_sck,
   output logic      o_ss_n,
   output logic      o_mosi,
   input  wire logic i_miso
);
   timeunit 1ns;
   timeprecision 1ns;
   import serdes_tx_pkg::*;
   localparam int HALF = 8;

   initial begin
      o_sck = 1'b0;
      o_ss_n = 1'b1;
      o_mosi = 1'b0;
   end

   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {cmd, dat};
      rdat = 8'h00;
      @(negedge i_clock);
      o_ss_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         o_mosi = sh[15-i];
         repeat (HALF) @(negedge i_clock);
         if (i >= 8) rdat = {rdat[6:0], i_miso};
         o_sck = 1'b1;
         repeat (HALF) @(negedge i_clock);
         o_sck = 1'b0;
      end
      repeat (HALF) @(negedge i_clock);
      o_ss_n = 1'b1;
      o_mosi = ~o_mosi;  // Released line never shows a stale level
      repeat (HALF) @(negedge i_clock);
   endtask

   task automatic wr(input logic [5:0] addr, input logic [7:0] dat);
      logic [7:0] d;
      logic [7:0] unused;
      d = (addr == ADDR_MISS_LIMIT) ? (dat & MISS_LIMIT_MASK) : dat;
      xfer({2'b10, addr}, d, unused);
   endtask
endmodule

// ===== serdes_tx.sv
// Transmit serializer with SPI register access and a byte FIFO.
// Assumes SPI mode 0 pins from another clock domain and a 50 MHz clock.

// ------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------
module tx_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0]      wr_ptr_ff;
   logic [AW:0]      rd_ptr_ff;

   wire same_lap = wr_ptr_ff[AW] == rd_ptr_ff[AW];
   wire same_idx = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];
   wire do_push  = i_in_valid & o_in_ready;
   wire do_pop   = o_out_valid & i_out_ready;

   assign o_in_ready  = ~(same_idx & ~same_lap);
   assign o_out_valid = ~(same_idx & same_lap);
   assign o_out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge i_clock) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + (AW+1)'(do_push);
         rd_ptr_ff <= rd_ptr_ff + (AW+1)'(do_pop);
      end
   end
endmodule

// ------------------------------------------------------------
// Top: SPI registers, flags and chip serializer
// ------------------------------------------------------------
module serdes_tx (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_spi_sck,
   input  wire logic       i_spi_ss_n,
   input  wire logic       i_spi_mosi,
   output logic            o_spi_miso,
   output logic            o_spi_miso_oe_n,
   output logic            o_tx_chip,
   output logic            o_tx_chip_valid,
   output logic            o_tx_preamble,
   output logic            o_tx_active,
   output logic            o_rx_enable,
   output logic [6:0]      o_zero_miss_limit
);
   import serdes_tx_pkg::*;

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic [1:0] sck_sync_ff;
   logic [1:0] ss_sync_ff;
   logic [1:0] mosi_sync_ff;
   logic       sck_prev_ff;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   wire rst_n = rst_sync_ff[1];

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         sck_sync_ff  <= 2'h0;
         ss_sync_ff   <= 2'h3;
         mosi_sync_ff <= 2'h0;
         sck_prev_ff  <= 1'b0;
      end else begin
         sck_sync_ff  <= {sck_sync_ff[0], i_spi_sck};
         ss_sync_ff   <= {ss_sync_ff[0], i_spi_ss_n};
         mosi_sync_ff <= {mosi_sync_ff[0], i_spi_mosi};
         sck_prev_ff  <= sck_sync_ff[1];
      end
   end

   // ------------------------------------------------------------
   // SPI frame: command byte, then data byte
   // ------------------------------------------------------------
   logic [4:0]  bit_cnt_ff;
   logic [15:0] shift_in_ff;
   logic [7:0]  miso_sh_ff;
   logic [7:0]  rdata;

   wire        frame_on   = ~ss_sync_ff[1];
   wire        sck_rise   = frame_on & sck_sync_ff[1] & ~sck_prev_ff;
   wire        sck_fall   = frame_on & ~sck_sync_ff[1] & sck_prev_ff;
   wire [15:0] nxt_shift  = {shift_in_ff[14:0], mosi_sync_ff[1]};
   wire        cmd_done   = sck_rise & (bit_cnt_ff == SPI_CMD_LAST);
   wire        frame_done = sck_rise & (bit_cnt_ff == SPI_FRAME_LAST);
   wire        data_phase = bit_cnt_ff > SPI_CMD_LAST + 5'h01; // Bit 7 holds to 9th rise
   wire [5:0]  rd_addr    = nxt_shift[5:0];
   wire        rd_strobe  = cmd_done & ~nxt_shift[SPI_WRITE_BIT];
   wire [5:0]  wr_addr    = nxt_shift[13:8];
   wire [7:0]  wr_data    = nxt_shift[7:0];
   wire        wr_strobe  = frame_done & nxt_shift[8 + SPI_WRITE_BIT];

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_ff  <= 5'h00;
         shift_in_ff <= 16'h0000;
         miso_sh_ff  <= 8'h00;
      end else if (!frame_on) begin
         bit_cnt_ff  <= 5'h00;
      end else begin
         if (sck_rise) begin
            shift_in_ff <= nxt_shift;
            bit_cnt_ff  <= bit_cnt_ff + 5'h01;
         end
         if (cmd_done) begin
            miso_sh_ff <= rdata;
         end else if (sck_fall && data_phase) begin
            miso_sh_ff <= {miso_sh_ff[6:0], 1'b0};
         end
      end
   end

   assign o_spi_miso      = miso_sh_ff[7];
   assign o_spi_miso_oe_n = ss_sync_ff[1];

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   logic [7:0]  control_ff;
   logic [7:0]  tx_byte_ff;
   logic [7:0]  tx_mask_ff;
   logic [7:0]  miss_limit_ff;
   code_mode_t  code_mode_ff;
   logic [7:0]  code_ff [8];
   tx_flags_t   flags_view;

   wire        wr_control = wr_strobe & (wr_addr == ADDR_CONTROL);
   wire        wr_tx_byte = wr_strobe & (wr_addr == ADDR_TX_BYTE);
   wire        wr_tx_mask = wr_strobe & (wr_addr == ADDR_TX_MASK);
   wire        wr_miss    = wr_strobe & (wr_addr == ADDR_MISS_LIMIT);
   wire        wr_mode    = wr_strobe & (wr_addr == ADDR_CODE_MODE);
   wire        wr_code    = wr_strobe & (wr_addr >= ADDR_CODE_FIRST)
                                      & (wr_addr <= ADDR_CODE_LAST);
   wire [2:0]  wr_code_ix = 3'(wr_addr - ADDR_CODE_FIRST);
   wire [2:0]  rd_code_ix = 3'(rd_addr - ADDR_CODE_FIRST);
   wire        tx_en      = control_ff[CTRL_TX_EN_BIT];
   wire        flags_read = rd_strobe & (rd_addr == ADDR_TX_FLAGS);

   always_comb begin
      if (rd_addr == ADDR_CONTROL) begin
         rdata = control_ff;
      end else if (rd_addr == ADDR_TX_FLAGS) begin
         rdata = flags_view;
      end else if (rd_addr == ADDR_TX_BYTE) begin
         rdata = tx_byte_ff;
      end else if (rd_addr == ADDR_TX_MASK) begin
         rdata = tx_mask_ff;
      end else if (rd_addr >= ADDR_CODE_FIRST && rd_addr <= ADDR_CODE_LAST) begin
         rdata = code_ff[rd_code_ix];
      end else if (rd_addr == ADDR_MISS_LIMIT) begin
         rdata = miss_limit_ff;
      end else if (rd_addr == ADDR_CODE_MODE) begin
         rdata = {6'h00, code_mode_ff};
      end else begin
         rdata = 8'h00;
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         control_ff    <= CONTROL_RESET;
         tx_byte_ff    <= TX_BYTE_RESET;
         tx_mask_ff    <= TX_MASK_RESET;
         miss_limit_ff <= MISS_LIMIT_RESET;
         code_mode_ff  <= CODE_FULL;
         for (int k = 0; k < 8; k++) begin
            code_ff[k] <= CODE_BYTE_RESET;
         end
      end else begin
         if (wr_control) begin
            control_ff <= wr_data;
         end
         if (wr_tx_byte) begin
            tx_byte_ff <= wr_data;
         end
         if (wr_tx_mask) begin
            tx_mask_ff <= wr_data;
         end
         if (wr_miss) begin
            miss_limit_ff <= wr_data & MISS_LIMIT_MASK;
         end
         if (wr_mode) begin
            code_mode_ff <= code_mode_t'(wr_data[1:0]);
         end
         if (wr_code) begin
            code_ff[wr_code_ix] <= wr_data;
         end
      end
   end

   assign o_rx_enable       = control_ff[CTRL_RX_EN_BIT];
   assign o_zero_miss_limit = miss_limit_ff[6:0];

   // ------------------------------------------------------------
   // FIFO between host writes and the serializer
   // ------------------------------------------------------------
   // Byte and mask are captured together, so a later mask write
   // cannot alter a byte already queued.
   tx_word_t   push_word;
   tx_word_t   head_word;
   logic [15:0] head_bits;
   logic       fifo_ready;
   logic       fifo_valid;
   logic       fifo_pop;

   assign push_word = '{data: wr_data, mask: tx_mask_ff};
   assign head_word = tx_word_t'(head_bits);

   tx_fifo #(
      .WIDTH ($bits(tx_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clock     (i_clock),
      .i_rst_n     (rst_n),
      .i_in_valid  (wr_tx_byte),
      .o_in_ready  (fifo_ready),
      .i_in_data   (push_word),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (head_bits)
   );

   // ------------------------------------------------------------
   // Chip-rate enable
   // ------------------------------------------------------------
   logic [5:0] div_cnt_ff;
   wire        chip_tick = div_cnt_ff == CHIP_DIV_LAST;

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_ff <= 6'h00;
      end else begin
         div_cnt_ff <= chip_tick ? 6'h00 : div_cnt_ff + 6'h01;
      end
   end

   // ------------------------------------------------------------
   // Serializer
   // ------------------------------------------------------------
   ser_state_t state_ff;
   ser_state_t nxt_state;
   logic [7:0] sh_data_ff;
   logic [7:0] sh_mask_ff;
   logic [5:0] chip_cnt_ff;
   logic       odd_bit_ff;
   logic       chip_ff;
   logic       chip_valid_ff;
   logic       preamble_ff;

   wire        idle      = state_ff == SER_IDLE;
   wire        full_code = code_mode_ff == CODE_FULL;
   wire [5:0]  last_chip = full_code ? LAST_CHIP_FULL : LAST_CHIP_HALF;
   wire        bit_end   = chip_tick & (chip_cnt_ff == last_chip);
   wire [7:0]  rest_mask = {1'b0, sh_mask_ff[7:1]};
   wire        byte_end  = ~idle & tx_en & bit_end & (rest_mask == 8'h00);
   wire        use_high  = (code_mode_ff == CODE_HIGH)
                         | ((code_mode_ff == CODE_DUAL) & odd_bit_ff);
   wire [5:0]  chip_ix   = full_code ? chip_cnt_ff
                                     : {use_high, chip_cnt_ff[4:0]};
   wire [63:0] code_vec  = {code_ff[7], code_ff[6], code_ff[5], code_ff[4],
                            code_ff[3], code_ff[2], code_ff[1], code_ff[0]};
   wire        is_data   = sh_mask_ff[0];
   wire        bit_val   = is_data ? sh_data_ff[0] : PREAMBLE_BIT;
   wire        nxt_chip  = code_vec[chip_ix] ^ ~bit_val;

   // Only an idle serializer pops, so a stalled transmitter lets the
   // FIFO fill and the overflow flag reports lost writes.
   assign fifo_pop = idle & tx_en & fifo_valid;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SER_IDLE: begin
            if (fifo_pop && head_word.mask != 8'h00) begin
               nxt_state = SER_SEND;
            end
         end
         SER_SEND: begin
            if (!tx_en || byte_end) begin
               nxt_state = SER_IDLE;
            end
         end
         default: begin
            nxt_state = SER_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= SER_IDLE;
         sh_data_ff  <= 8'h00;
         sh_mask_ff  <= 8'h00;
         chip_cnt_ff <= 6'h00;
         odd_bit_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (fifo_pop) begin
            sh_data_ff  <= head_word.data;
            sh_mask_ff  <= head_word.mask;
            chip_cnt_ff <= 6'h00;
            odd_bit_ff  <= 1'b0;
         end else if (!idle && bit_end) begin
            sh_data_ff  <= {1'b0, sh_data_ff[7:1]};
            sh_mask_ff  <= rest_mask;
            chip_cnt_ff <= 6'h00;
            odd_bit_ff  <= ~odd_bit_ff;
         end else if (!idle && chip_tick) begin
            chip_cnt_ff <= chip_cnt_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         chip_ff       <= 1'b0;
         chip_valid_ff <= 1'b0;
         preamble_ff   <= 1'b0;
      end else begin
         chip_valid_ff <= ~idle & tx_en & chip_tick;
         if (!idle && chip_tick) begin
            chip_ff     <= nxt_chip;
            preamble_ff <= ~is_data;
         end
      end
   end

   assign o_tx_chip       = chip_ff;
   assign o_tx_chip_valid = chip_valid_ff;
   assign o_tx_preamble   = preamble_ff;
   assign o_tx_active     = ~idle;

   // ------------------------------------------------------------
   // Transmit flags
   // ------------------------------------------------------------
   // Done, overflow and underflow clear when read; a set in the same cycle wins.
   logic done_ff;
   logic overflow_ff;
   logic underflow_ff;
   logic sent_once_ff;

   wire set_overflow  = wr_tx_byte & ~fifo_ready;
   wire set_underflow = byte_end & ~fifo_valid;
   wire nxt_done      = byte_end | (done_ff & ~flags_read);
   wire nxt_overflow  = set_overflow | (overflow_ff & ~flags_read);
   wire nxt_underflow = set_underflow | (underflow_ff & ~flags_read);

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         done_ff      <= 1'b0;
         overflow_ff  <= 1'b0;
         underflow_ff <= 1'b0;
         sent_once_ff <= 1'b0;
      end else begin
         // Writes never reach these bits.
         done_ff      <= nxt_done;
         overflow_ff  <= nxt_overflow;
         underflow_ff <= nxt_underflow & (sent_once_ff | byte_end);
         sent_once_ff <= sent_once_ff | byte_end;
      end
   end

   // Empty tracks the FIFO level, so loading a byte clears it.
   assign flags_view = tx_en ? tx_flags_t'{zero: 4'h0,
                                 underflow: underflow_ff,
                                 overflow: overflow_ff,
                                 done: done_ff,
                                 empty: ~fifo_valid}
                             : '0;
endmodule

// ===== serdes_tx_chk.sv
// Concurrent checks on the ports of the transmit serializer top.
// Assumes one clock domain and the bind at the foot of this file.
module serdes_tx_chk (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic       i_spi_sck,
   input  wire logic       i_spi_ss_n,
   input  wire logic       i_spi_mosi,
   input  wire logic       o_spi_miso,
   input  wire logic       o_spi_miso_oe_n,
   input  wire logic       o_tx_chip,
   input  wire logic       o_tx_chip_valid,
   input  wire logic       o_tx_preamble,
   input  wire logic       o_tx_active,
   input  wire logic       o_rx_enable,
   input  wire logic [6:0] o_zero_miss_limit
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // ------------------------------------------------------------
   // Cycles since the last chip, saturating
   // ------------------------------------------------------------
   logic [6:0] gap_ff;
   logic [6:0] nxt_gap;
   assign nxt_gap = o_tx_chip_valid ? 7'h00 : ((gap_ff == 7'h7f) ? gap_ff : gap_ff + 7'h01);
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) gap_ff <= 7'h7f;
      else gap_ff <= nxt_gap;
   end

   sequence chip_beat;
      o_tx_chip_valid;
   endsequence
   sequence byte_start;
      $rose(o_tx_active);
   endsequence

   chip_gap_a: assert property (chip_beat |-> gap_ff >= 7'h31)
      else $error("chip issued sooner than one chip period");
   chip_hold_a: assert property (o_tx_active && $changed(o_tx_chip) |-> o_tx_chip_valid)
      else $error("chip changed without a chip strobe");
   pre_hold_a: assert property (o_tx_active && $changed(o_tx_preamble) |-> o_tx_chip_valid)
      else $error("preamble flag changed inside a chip");
   first_chip_a: assert property (byte_start |-> ##[1:52] chip_beat)
      else $error("no chip soon after byte start");
   byte_end_a: assert property ($fell(o_tx_active) |-> ##[0:1] (o_tx_chip_valid || gap_ff == 7'h00))
      else $error("sending stopped away from a chip boundary");
   chip_quiet_a: assert property (!o_tx_active && !$past(o_tx_active) |-> !o_tx_chip_valid)
      else $error("chip strobe while idle");
   oe_on_a: assert property ($fell(i_spi_ss_n) |-> ##[1:4] !o_spi_miso_oe_n)
      else $error("read data pin not enabled after select");
   oe_off_a: assert property ($rose(i_spi_ss_n) |-> ##[1:4] o_spi_miso_oe_n)
      else $error("read data pin not released after deselect");
   limit_reset_a: assert property ($rose(i_rst_n) |-> o_zero_miss_limit == 7'h08)
      else $error("miss limit not at reset value");
endmodule

bind serdes_tx serdes_tx_chk chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_spi_sck(i_spi_sck), .i_spi_ss_n(i_spi_ss_n), .i_spi_mosi(i_spi_mosi),
   .o_spi_miso(o_spi_miso), .o_spi_miso_oe_n(o_spi_miso_oe_n), .o_tx_chip(o_tx_chip),
   .o_tx_chip_valid(o_tx_chip_valid), .o_tx_preamble(o_tx_preamble),
   .o_tx_active(o_tx_active), .o_rx_enable(o_rx_enable),
   .o_zero_miss_limit(o_zero_miss_limit));

// ===== serdes_tx_pkg.sv
// Constants, types and encodings of the transmit serializer block.
// Assumes a host on the SPI pins and a chip-rate radio front end.
package serdes_tx_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [5:0] ADDR_CONTROL    = 6'h03;
   localparam logic [5:0] ADDR_TX_FLAGS   = 6'h09;
   localparam logic [5:0] ADDR_TX_BYTE    = 6'h0f;
   localparam logic [5:0] ADDR_TX_MASK    = 6'h10;
   localparam logic [5:0] ADDR_CODE_FIRST = 6'h11;
   localparam logic [5:0] ADDR_CODE_LAST  = 6'h18;
   localparam logic [5:0] ADDR_MISS_LIMIT = 6'h19;
   localparam logic [5:0] ADDR_CODE_MODE  = 6'h1e;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int         CTRL_TX_EN_BIT   = 7;
   localparam int         CTRL_RX_EN_BIT   = 6;
   localparam int         SPI_WRITE_BIT    = 7;
   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] TX_BYTE_RESET    = 8'h00;
   localparam logic [7:0] TX_MASK_RESET    = 8'h00;
   localparam logic [7:0] MISS_LIMIT_RESET = 8'h08;
   localparam logic [7:0] MISS_LIMIT_MASK  = 8'h7f;
   localparam logic [7:0] CODE_BYTE_RESET  = 8'h00;
   localparam logic       PREAMBLE_BIT     = 1'b1;

   // ------------------------------------------------------------
   // Timing and sizes
   // ------------------------------------------------------------
   localparam int         CLOCK_PERIOD_NS = 20;
   localparam int         CHIP_PERIOD_NS  = 1000;
   localparam int         CHIP_DIV        = CHIP_PERIOD_NS / CLOCK_PERIOD_NS;
   localparam logic [5:0] CHIP_DIV_LAST   = 6'(CHIP_DIV - 1);
   localparam logic [5:0] LAST_CHIP_FULL  = 6'h3f;
   localparam logic [5:0] LAST_CHIP_HALF  = 6'h1f;
   localparam logic [4:0] SPI_CMD_LAST    = 5'h07;
   localparam logic [4:0] SPI_FRAME_LAST  = 5'h0f;
   localparam int         FIFO_DEPTH      = 8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CODE_FULL = 2'b00,
      CODE_LOW  = 2'b01,
      CODE_HIGH = 2'b10,
      CODE_DUAL = 2'b11
   } code_mode_t;

   typedef enum logic {
      SER_IDLE = 1'b0,
      SER_SEND = 1'b1
   } ser_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] mask;
   } tx_word_t;

   typedef struct packed {
      logic [3:0] zero;
      logic       underflow;
      logic       overflow;
      logic       done;
      logic       empty;
   } tx_flags_t;

endpackage

// ===== test_serdes_tx_spreading_code.sv
// Self-checking bench: registers, flags and chip stream of the serializer.
// Assumes the host model on SPI and the bound port checker.
module test_serdes_tx_spreading_code;
   timeunit 1ns;
   timeprecision 1ns;
   import serdes_tx_pkg::*;

   logic       clk, rst_n, sck, ss_n, mosi, miso, miso_oe_n;
   logic       chip, chip_v, pre, act, rx_en;
   logic [6:0] miss;
   logic [7:0] rnd, r;
   logic [7:0] code_b [8];
   logic [1:0] cap [$];
   logic [1:0] exp_q [$];
   int         error_cnt, total_checks;
   logic [5:0] ra [6] = '{ADDR_TX_BYTE, ADDR_TX_MASK, ADDR_MISS_LIMIT, ADDR_CODE_FIRST, 6'h3f, ADDR_TX_FLAGS};
   logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
   logic [7:0] mk [4] = '{8'h03, 8'hf0, 8'h05, 8'h0f};

   serdes_tx dut_u (.i_clock(clk), .i_rst_n(rst_n), .i_spi_sck(sck), .i_spi_ss_n(ss_n),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(miso_oe_n), .o_tx_chip(chip),
      .o_tx_chip_valid(chip_v), .o_tx_preamble(pre), .o_tx_active(act), .o_rx_enable(rx_en),
      .o_zero_miss_limit(miss));
   host_spi_model host_u (.i_clock(clk), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .i_miso(miso));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(negedge clk) begin
      if (chip_v === 1'b1) cap.push_back({pre, chip});
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Chips expected for one byte; preamble bit times send value one
   function automatic void expect_byte(input logic [7:0] d, input logic [7:0] m, input logic [1:0] mode);
      int top, lo, n;
      logic [63:0] code;
      logic v;
      top = 0;
      for (int i = 0; i < 8; i++) code[8*i+:8] = code_b[i];
      for (int b = 0; b < 8; b++) if (m[b]) top = b;
      for (int b = 0; b <= top; b++) begin
         v = m[b] ? d[b] : PREAMBLE_BIT;
         lo = (mode == CODE_HIGH || (mode == CODE_DUAL && b % 2 == 1)) ? 32 : 0;
         n = (mode == CODE_FULL) ? 64 : 32;
         for (int i = lo; i < lo + n; i++) exp_q.push_back({~m[b], code[i] ^ ~v});
      end
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      host_u.xfer({2'b00, a}, 8'h00, d);
   endtask

   task automatic send(input logic [7:0] d, input logic [7:0] m, input logic [1:0] mode);
      host_u.wr(ADDR_TX_MASK, m);
      host_u.wr(ADDR_TX_BYTE, d);
      expect_byte(d, m, mode);
   endtask

   // Extra idle time catches chips sent past the last valid bit
   task automatic drain;
      for (int k = 0; k < 40000 && cap.size() < exp_q.size(); k++) @(negedge clk);
      repeat (200) @(negedge clk);
      check(16'(cap.size()), 16'(exp_q.size()));
      foreach (exp_q[j]) check({14'h0, cap[j]}, {14'h0, exp_q[j]});
      cap.delete();
      exp_q.delete();
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      error_cnt++;
      conclude();
   end

   initial begin
      rst_n = 1'b0;
      rnd = 8'h1b;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
      check({9'h0, miss}, 16'h0008);
      foreach (ra[i]) begin
         rd(ra[i], r);
         check({8'h0, r}, {8'h0, rv[i]});
      end
      host_u.xfer({2'b10, ADDR_MISS_LIMIT}, 8'hff, r);
      rd(ADDR_MISS_LIMIT, r);
      check({8'h0, r}, 16'h007f);
      host_u.wr(ADDR_CONTROL, 8'h40);
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0000);
      host_u.wr(ADDR_CONTROL, 8'hc0);
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0001);
      host_u.wr(ADDR_TX_FLAGS, 8'hff);
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0001);
      // Random test codes; correlation quality is moot for transmit
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr_next(rnd);
         code_b[i] = rnd;
         host_u.wr(ADDR_CODE_FIRST + 6'(i), rnd);
      end
      for (int i = 0; i < 4; i++) begin
         host_u.wr(ADDR_CODE_MODE, 8'(i));
         rnd = lfsr_next(rnd);
         send(rnd, mk[i], 2'(i));
         drain();
      end
      host_u.wr(ADDR_CODE_MODE, 8'h01);
      rnd = lfsr_next(rnd);
      send(rnd, 8'h01, 2'h1);
      send(~rnd, 8'h80, 2'h1);
      drain();
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h000b);
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0001);
      host_u.wr(ADDR_CONTROL, 8'h00);
      host_u.wr(ADDR_TX_MASK, 8'h00);
      for (int i = 0; i < FIFO_DEPTH; i++) host_u.wr(ADDR_TX_BYTE, 8'(i));
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0000);
      host_u.wr(ADDR_TX_BYTE, 8'h5a);
      host_u.wr(ADDR_CONTROL, 8'h80);
      repeat (20) @(negedge clk);
      check({15'h0, rx_en}, 16'h0000);
      rd(ADDR_TX_FLAGS, r);
      check({8'h0, r}, 16'h0005);
      check(16'(cap.size()), 16'h0000);
      conclude();
   end
endmodule
